// file: sbl_bank.sv
`timescale 1ns/100ps
`include "sbl_params.svh"

module sbl_bank
  import sbl_pkg::*;
(
  input wire logic clk_link,
  input wire logic rst_n,
  input wire logic en,
  input wire sbl_cmd_t cmd,
  input wire logic hit,
  input wire logic auto_pre,
  input wire logic bl8,
  output logic idle,
  output logic illegal
);

  localparam logic [3:0] TRP_C = 4'(`SBL_TRP_CYC);
  localparam logic [3:0] TRCD_C = 4'(`SBL_TRCD_CYC);
  localparam logic [3:0] TWR_C = 4'(`SBL_TWR_CYC);

  sbl_bank_state_t state, next_state;
  logic [3:0] tmr, next_tmr;
  logic next_illegal;
  logic quiet, expired;
  logic [3:0] blen;

  assign idle = (state == bank_idle);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    quiet = (cmd == deselect_cmd) || (cmd == no_operation_cmd);
    expired = (tmr == 4'h1);
    // the command clock is the first clock of the burst
    blen = (bl8 ? `SBL_BL8_CLK : `SBL_BL4_CLK) - 4'h1;
    next_state = state;
    next_tmr = (tmr == 4'h0) ? 4'h0 : tmr - 4'h1;
    next_illegal = 1'b0;
    unique case (state)
      bank_idle: begin
        if (hit && cmd == row_activate_cmd) begin
          next_state = bank_activating;
          next_tmr = TRCD_C;
        end else if (hit && (cmd == read_cmd || cmd == write_cmd)) begin
          next_illegal = 1'b1;
        end
      end
      bank_activating: begin
        if (hit && !quiet) next_illegal = 1'b1;
        if (expired) next_state = bank_active;
      end
      bank_active: begin
        if (hit && cmd == read_cmd) begin
          next_state = auto_pre ? bank_read_ap : bank_read;
          next_tmr = blen;
        end else if (hit && cmd == write_cmd) begin
          next_state = auto_pre ? bank_write_ap : bank_write;
          next_tmr = blen;
        end else if (hit && cmd == precharge_cmd) begin
          next_state = bank_precharging;
          next_tmr = TRP_C;
        end else if (hit && !quiet) begin
          next_illegal = 1'b1;
        end
      end
      bank_read, bank_write: begin
        // only a same-kind column command on the 4-beat boundary of an 8-beat burst restarts
        if (hit && !quiet && bl8 && tmr == `SBL_BOUNDARY_CNT &&
            cmd == ((state == bank_read) ? read_cmd : write_cmd)) begin
          next_tmr = blen;
          if (state == bank_read) next_state = auto_pre ? bank_read_ap : bank_read;
          else next_state = auto_pre ? bank_write_ap : bank_write;
        end else begin
          // a refused command must not stall the burst on its last clock
          if (hit && !quiet) next_illegal = 1'b1;
          if (expired) begin
            next_state = (state == bank_read) ? bank_active : bank_wr_recover;
            next_tmr = (state == bank_read) ? 4'h0 : TWR_C;
          end
        end
      end
      bank_read_ap, bank_write_ap: begin
        if (hit && !quiet) next_illegal = 1'b1;
        if (expired) begin
          next_state = (state == bank_read_ap) ? bank_precharging : bank_wr_recover_ap;
          next_tmr = (state == bank_read_ap) ? TRP_C : TWR_C;
        end
      end
      bank_precharging: begin
        if (hit && !quiet && cmd != precharge_cmd) next_illegal = 1'b1;
        if (expired) next_state = bank_idle;
      end
      bank_wr_recover: begin
        if (hit && cmd == write_cmd) begin
          next_state = auto_pre ? bank_write_ap : bank_write;
          next_tmr = blen;
        end else begin
          if (hit && !quiet) next_illegal = 1'b1;
          if (expired) next_state = bank_active;
        end
      end
      bank_wr_recover_ap: begin
        if (hit && !quiet) next_illegal = 1'b1;
        if (expired) begin
          next_state = bank_precharging;
          next_tmr = TRP_C;
        end
      end
      default: begin
        next_state = bank_idle;
        next_tmr = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      state <= bank_idle;
      tmr <= 4'h0;
      illegal <= 1'b0;
    end else if (en) begin
      state <= next_state;
      tmr <= next_tmr;
      illegal <= next_illegal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  activate_entry_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    en && state == bank_idle && hit && cmd == row_activate_cmd |=> state == bank_activating)
    else $error("activate did not start row activation");
  activate_busy_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    en && state == bank_activating && hit && !quiet |=> illegal)
    else $error("command during activation not flagged");
  precharge_done_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    en && state == bank_precharging && tmr == 4'h1 |=> state == bank_idle)
    else $error("precharge did not end in idle");
  recover_write_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    en && state == bank_wr_recover && hit && cmd == write_cmd |=> !illegal && state inside {bank_write, bank_write_ap})
    else $error("write during recovery refused");
  recover_ap_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    en && state == bank_wr_recover_ap && tmr == 4'h1 |=> state == bank_precharging && tmr == TRP_C)
    else $error("auto-precharge recovery did not precharge");
  ap_burst_guard_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    en && state inside {bank_read_ap, bank_write_ap} && hit && !quiet |=> illegal)
    else $error("command to auto-precharge burst not flagged");
  short_burst_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    en && !bl8 && state == bank_read && hit && cmd == read_cmd |=> illegal)
    else $error("4-beat burst interrupted");
  burst_restart_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    en && bl8 && state == bank_read && tmr == `SBL_BOUNDARY_CNT && hit && cmd == read_cmd |=>
      !illegal && state inside {bank_read, bank_read_ap})
    else $error("read on burst boundary refused");

endmodule : sbl_bank

// file: sbl_cmd_legality.sv
`timescale 1ns/100ps
`include "sbl_params.svh"

module sbl_cmd_legality
  import sbl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic clk_link,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_addr,
  input wire logic addr_ap,
  input wire logic [`SBL_BL_W-1:0] mode_addr,
  output logic [`SBL_NUM_BANKS-1:0] bank_busy,
  output logic dev_busy,
  output logic burst8_mode,
  output logic illegal_pulse
);

  localparam logic [3:0] TRC_C = 4'(`SBL_TRC_CYC);
  localparam logic [3:0] TMRD_C = 4'(`SBL_TMRD_CK);
  localparam int TRC_I = `SBL_TRC_CYC;
  localparam int TMRD_I = `SBL_TMRD_CK;

  ////////////////////////////////////////////////////////////////////////////
  // clock enable into the link domain; freezes link state once settled
  logic [2:0] en_sync, next_en_sync;
  logic link_en, next_link_en;

  always_comb begin
    next_en_sync = {en_sync[1:0], clk_en};
    next_link_en = (en_sync[1] == en_sync[2]) ? en_sync[2] : link_en;
  end

  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      en_sync <= 3'h0;
      link_en <= 1'b0;
    end else begin
      en_sync <= next_en_sync;
      link_en <= next_link_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins are launched by the controller on this same clock, so no synchroniser
  logic cs_q, ras_q, cas_q, we_q, ap_q;
  logic [1:0] ba_q;
  logic [`SBL_BL_W-1:0] ma_q;
  sbl_cmd_t cmd;
  logic [2:0] pin_code;

  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      cs_q <= 1'b1;
      ras_q <= 1'b1;
      cas_q <= 1'b1;
      we_q <= 1'b1;
      ap_q <= 1'b0;
      ba_q <= 2'h0;
      ma_q <= '0;
    end else if (link_en) begin
      cs_q <= cs_n;
      ras_q <= ras_n;
      cas_q <= cas_n;
      we_q <= we_n;
      ap_q <= addr_ap;
      ba_q <= bank_addr;
      ma_q <= mode_addr;
    end
  end

  always_comb begin
    pin_code = {~ras_q, ~cas_q, ~we_q};
    if (cs_q) cmd = deselect_cmd;
    // the unlisted high-high-high pattern is taken as no operation
    else if (pin_code[2:1] == 2'h0) cmd = no_operation_cmd;
    else cmd = sbl_cmd_t'(pin_code);
  end

  ////////////////////////////////////////////////////////////////////////////
  // device-wide refresh and mode-register phases
  sbl_dev_state_t dev_state, next_dev_state;
  logic [3:0] dev_tmr, next_dev_tmr;
  logic bl8, next_bl8;
  logic dev_bad, quiet, all_idle;
  logic tog, next_tog;
  logic [`SBL_NUM_BANKS-1:0] bank_idle, bank_bad;
  sbl_cmd_t bank_cmd;

  assign all_idle = &bank_idle;

  always_comb begin
    quiet = (cmd == deselect_cmd) || (cmd == no_operation_cmd);
    next_dev_state = dev_state;
    next_dev_tmr = (dev_tmr == 4'h0) ? 4'h0 : dev_tmr - 4'h1;
    next_bl8 = bl8;
    dev_bad = 1'b0;
    bank_cmd = cmd;
    unique case (dev_state)
      dev_normal: begin
        if (cmd == refresh_cmd || cmd == mode_set_cmd) begin
          bank_cmd = deselect_cmd;
          if (!all_idle) begin
            dev_bad = 1'b1;
          end else if (cmd == refresh_cmd) begin
            next_dev_state = dev_refreshing;
            next_dev_tmr = TRC_C;
          end else begin
            next_dev_state = dev_mode_access;
            next_dev_tmr = TMRD_C;
            if (ba_q == `SBL_MODE_BANK) next_bl8 = (ma_q == `SBL_BL8_CODE);
          end
        end
      end
      dev_refreshing, dev_mode_access: begin
        // banks see nothing while the whole device is busy
        bank_cmd = deselect_cmd;
        if (!quiet) dev_bad = 1'b1;
        if (dev_tmr == 4'h1) next_dev_state = dev_normal;
      end
      default: begin
        next_dev_state = dev_normal;
        next_dev_tmr = 4'h0;
      end
    endcase
    next_tog = tog ^ (dev_bad | (|bank_bad));
  end

  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      dev_state <= dev_normal;
      dev_tmr <= 4'h0;
      bl8 <= 1'b0;
      tog <= 1'b0;
    end else if (link_en) begin
      dev_state <= next_dev_state;
      dev_tmr <= next_dev_tmr;
      bl8 <= next_bl8;
      tog <= next_tog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one tracker per bank; only the addressed bank judges a command, except a precharge with addr_ap set, which every bank judges
  for (genvar gi = 0; gi < `SBL_NUM_BANKS; gi++) begin : g_bank
    sbl_bank u_bank (
      .clk_link(clk_link),
      .rst_n(rst_n),
      .en(link_en),
      .cmd(bank_cmd),
      .hit((ba_q == 2'(gi)) || (bank_cmd == precharge_cmd && ap_q)),
      .auto_pre(ap_q),
      .bl8(bl8),
      .idle(bank_idle[gi]),
      .illegal(bank_bad[gi])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // into clk_sys: levels and the error toggle, three stages, taken when two agree
  logic [`SBL_SYNC_W-1:0] link_lvl;
  logic [`SBL_SYNC_W-1:0] s1, s2, s3, held, next_held;
  logic next_illegal_pulse;

  assign link_lvl = {tog, bl8, dev_state != dev_normal, ~bank_idle};

  always_comb begin
    next_held = (s2 & ~(s2 ^ s3)) | (held & (s2 ^ s3));
    next_illegal_pulse = (next_held[`SBL_SYNC_W-1] != held[`SBL_SYNC_W-1]);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      held <= '0;
      bank_busy <= '0;
      dev_busy <= 1'b0;
      burst8_mode <= 1'b0;
      illegal_pulse <= 1'b0;
    end else if (clk_en) begin
      s1 <= link_lvl;
      s2 <= s1;
      s3 <= s2;
      held <= next_held;
      bank_busy <= next_held[`SBL_NUM_BANKS-1:0];
      dev_busy <= next_held[`SBL_NUM_BANKS];
      burst8_mode <= next_held[`SBL_NUM_BANKS+1];
      illegal_pulse <= next_illegal_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence refresh_taken_s;
    link_en && dev_state == dev_normal && cmd == refresh_cmd && all_idle;
  endsequence

  sequence mode_taken_s;
    link_en && dev_state == dev_normal && cmd == mode_set_cmd && all_idle;
  endsequence

  decode_refresh_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    link_en && !cs_n && !ras_n && !cas_n && we_n |=> cmd == refresh_cmd)
    else $error("refresh pattern decoded wrongly");
  refresh_phase_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    refresh_taken_s |=> dev_state == dev_refreshing && dev_tmr == TRC_C)
    else $error("refresh did not start the row cycle");
  refresh_ends_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    refresh_taken_s ##1 link_en [*1] |-> ##[0:TRC_I] dev_state == dev_normal)
    else $error("refresh phase overran");
  mode_ends_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    mode_taken_s ##1 link_en [*1] |-> ##[0:TMRD_I] dev_state == dev_normal)
    else $error("mode access phase overran");
  mode_guard_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    link_en && dev_state == dev_mode_access && !quiet |=> tog != $past(tog))
    else $error("command during mode access not flagged");
  busy_refresh_a: assert property (@(posedge clk_link) disable iff (!rst_n)
    link_en && dev_state == dev_normal && cmd == refresh_cmd && !all_idle |=> dev_state == dev_normal && tog != $past(tog))
    else $error("refresh with open bank accepted");

endmodule : sbl_cmd_legality

// file: sbl_ctrl_model.sv
`timescale 1ns/100ps

module sbl_ctrl_model
  import sbl_pkg::*;
(
  input wire logic clk_link,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bank_addr,
  output logic addr_ap,
  output logic [2:0] mode_addr
);
  integer seed = 32'h12769475;

  initial begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n, bank_addr, addr_ap, mode_addr} = 9'h1ff;
  end

  ////////////////////////////////////////////////////////////////
  // deselected cycles carry random levels on the other pins, so a
  // decoder that looks past the select line is caught
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_link);
      cs_n = 1'b1;
      {ras_n, cas_n, we_n, bank_addr, addr_ap, mode_addr} = 9'($random(seed));
    end
  endtask : idle

  ////////////////////////////////////////////////////////////////
  // one command, held for exactly one link edge
  task automatic send(input sbl_cmd_t c, input logic [1:0] b, input logic ap, input logic [2:0] m);
    @(negedge clk_link);
    cs_n = 1'b0;
    case (c)
      read_cmd: {ras_n, cas_n, we_n} = 3'h5;
      write_cmd: {ras_n, cas_n, we_n} = 3'h4;
      row_activate_cmd: {ras_n, cas_n, we_n} = 3'h3;
      precharge_cmd: {ras_n, cas_n, we_n} = 3'h2;
      refresh_cmd: {ras_n, cas_n, we_n} = 3'h1;
      mode_set_cmd: {ras_n, cas_n, we_n} = 3'h0;
      default: {ras_n, cas_n, we_n} = 3'h7;
    endcase
    bank_addr = b;
    addr_ap = ap;
    mode_addr = (c == mode_set_cmd) ? m : 3'($random(seed));
  endtask : send
endmodule : sbl_ctrl_model

// file: sbl_params.svh
`ifndef SBL_PARAMS_SVH
`define SBL_PARAMS_SVH

// link clock period used to turn times into link cycles
`define SBL_LINK_PERIOD_NS 80
`define SBL_TRP_NS 15
`define SBL_TRCD_NS 15
`define SBL_TWR_NS 15
`define SBL_TRC_NS 60
// mode-set delay is specified in link clocks
`define SBL_TMRD_CK 2

// least times round up, never below one cycle
`define SBL_CEIL_CYC(ns) (((ns) + `SBL_LINK_PERIOD_NS - 1) / `SBL_LINK_PERIOD_NS < 1 ? 1 : \
  ((ns) + `SBL_LINK_PERIOD_NS - 1) / `SBL_LINK_PERIOD_NS)
`define SBL_TRP_CYC `SBL_CEIL_CYC(`SBL_TRP_NS)
`define SBL_TRCD_CYC `SBL_CEIL_CYC(`SBL_TRCD_NS)
`define SBL_TWR_CYC `SBL_CEIL_CYC(`SBL_TWR_NS)
`define SBL_TRC_CYC `SBL_CEIL_CYC(`SBL_TRC_NS)

// burst lengths in link clocks (two beats per clock)
`define SBL_BL4_CLK 4'h2
`define SBL_BL8_CLK 4'h4
// remaining count at the 4-beat boundary of an 8-beat burst
`define SBL_BOUNDARY_CNT 4'h2

// burst length field taken from the low address bits on a mode set to bank 0
`define SBL_BL_LSB 0
`define SBL_BL_W 3
`define SBL_BL8_CODE 3'h3
`define SBL_MODE_BANK 2'h0

`define SBL_NUM_BANKS 4
`define SBL_SYNC_W 7

`endif

// file: sbl_pkg.sv
package sbl_pkg;

  typedef enum logic [2:0] {
    deselect_cmd = 3'h0,
    no_operation_cmd = 3'h1,
    read_cmd = 3'h2,
    write_cmd = 3'h3,
    row_activate_cmd = 3'h4,
    precharge_cmd = 3'h5,
    refresh_cmd = 3'h6,
    mode_set_cmd = 3'h7
  } sbl_cmd_t;

  typedef enum logic [3:0] {
    bank_idle = 4'h0,
    bank_activating = 4'h1,
    bank_active = 4'h2,
    bank_read = 4'h3,
    bank_write = 4'h4,
    bank_read_ap = 4'h5,
    bank_write_ap = 4'h6,
    bank_precharging = 4'h7,
    bank_wr_recover = 4'h8,
    bank_wr_recover_ap = 4'h9
  } sbl_bank_state_t;

  typedef enum logic [1:0] {
    dev_normal = 2'h0,
    dev_refreshing = 2'h1,
    dev_mode_access = 2'h2
  } sbl_dev_state_t;

endpackage : sbl_pkg

// file: test_sbl_cmd_legality.sv
`timescale 1ns/100ps

module test_sbl_cmd_legality
  import sbl_pkg::*;
;
  typedef struct packed {
    logic [3:0] busy;
    logic b8;
    int ill;
  } sbl_note_t;

  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst_n;
  logic clk_en;
  logic cs_n, ras_n, cas_n, we_n, addr_ap;
  logic [1:0] bank_addr;
  logic [2:0] mode_addr;
  logic [3:0] bank_busy;
  logic dev_busy, burst8_mode, illegal_pulse;
  sbl_note_t notes[$];
  int n_errors = 0;
  int tests_run = 0;
  int n_ill = 0;
  int exp_ill = 0;

  initial forever #50 clk_sys = ~clk_sys;
  // link clock offset so its edges never line up with the system clock
  initial begin
    #17;
    forever #40 clk_link = ~clk_link;
  end

  sbl_cmd_legality dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .clk_link(clk_link),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr),
    .addr_ap(addr_ap), .mode_addr(mode_addr), .bank_busy(bank_busy), .dev_busy(dev_busy),
    .burst8_mode(burst8_mode), .illegal_pulse(illegal_pulse));

  sbl_ctrl_model u_ctrl (.clk_link(clk_link), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_addr(bank_addr), .addr_ap(addr_ap), .mode_addr(mode_addr));

  // a frozen pulse is counted once, at the edge that replaces it
  always @(posedge clk_sys) if (clk_en && illegal_pulse === 1'b1) n_ill <= n_ill + 1;

  ////////////////////////////////////////////////////////////////
  task automatic chk4(input string nm, input logic [3:0] e, input logic [3:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk4

  task automatic chk1(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  task automatic chkn(input string nm, input int e, input int g);
    tests_run++;
    if (g != e) begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chkn

  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic issue(input sbl_cmd_t c, input logic [1:0] b, input logic ap = 1'b0,
                       input logic [2:0] m = 3'h0);
    u_ctrl.send(c, b, ap, m);
  endtask : issue

  // one illegal event per step at most: two close events may cancel and give no pulse
  task automatic step(input logic [3:0] busy, input logic b8, input int dill);
    sbl_note_t nt;
    u_ctrl.idle(4);
    exp_ill += dill;
    nt.busy = busy;
    nt.b8 = b8;
    nt.ill = exp_ill;
    notes.push_back(nt);
    wait (notes.size() == 0);
  endtask : step

  ////////////////////////////////////////////////////////////////
  // watcher: settled outputs against the oldest note
  initial begin
    sbl_note_t nt;
    forever begin
      wait (notes.size() > 0);
      repeat (14) @(negedge clk_sys);
      nt = notes[0];
      chk4("bank_busy", nt.busy, bank_busy);
      chk1("dev_busy", 1'b0, dev_busy);
      chk1("burst8_mode", nt.b8, burst8_mode);
      chkn("illegal_count", nt.ill, n_ill);
      void'(notes.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b0;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    clk_en = 1'b1;
    u_ctrl.idle(8);
    step(4'h0, 1'b0, 0);
    issue(read_cmd, 2'h0); step(4'h0, 1'b0, 1);
    issue(row_activate_cmd, 2'h1); step(4'h2, 1'b0, 0);
    issue(row_activate_cmd, 2'h2); issue(read_cmd, 2'h2); step(4'h6, 1'b0, 1);
    issue(row_activate_cmd, 2'h1); step(4'h6, 1'b0, 1);
    issue(read_cmd, 2'h1, 1'b1); issue(write_cmd, 2'h1); step(4'h4, 1'b0, 1);
    issue(precharge_cmd, 2'h2); issue(precharge_cmd, 2'h2); step(4'h0, 1'b0, 0);
    issue(row_activate_cmd, 2'h0); u_ctrl.idle(2);
    issue(precharge_cmd, 2'h0); issue(row_activate_cmd, 2'h0); step(4'h0, 1'b0, 1);
    issue(row_activate_cmd, 2'h3); u_ctrl.idle(2);
    issue(write_cmd, 2'h3, 1'b1); u_ctrl.idle(1); issue(read_cmd, 2'h3); step(4'h0, 1'b0, 1);
    issue(row_activate_cmd, 2'h3); u_ctrl.idle(2);
    issue(write_cmd, 2'h3); step(4'h8, 1'b0, 0);
    issue(refresh_cmd, 2'h0); step(4'h8, 1'b0, 1);
    issue(precharge_cmd, 2'h0, 1'b1); step(4'h0, 1'b0, 0);
    issue(refresh_cmd, 2'h0); issue(row_activate_cmd, 2'h1); step(4'h0, 1'b0, 1);
    issue(mode_set_cmd, 2'h0, 1'b0, 3'h3); issue(row_activate_cmd, 2'h1); step(4'h0, 1'b1, 1);
    issue(row_activate_cmd, 2'h1); u_ctrl.idle(2);
    issue(read_cmd, 2'h1); u_ctrl.idle(1); issue(read_cmd, 2'h1); step(4'h2, 1'b1, 0);
    issue(read_cmd, 2'h1); issue(read_cmd, 2'h1); step(4'h2, 1'b1, 1);
    issue(write_cmd, 2'h1); u_ctrl.idle(1); issue(read_cmd, 2'h1); step(4'h2, 1'b1, 1);
    issue(mode_set_cmd, 2'h0, 1'b0, 3'h2); step(4'h2, 1'b1, 1);
    issue(precharge_cmd, 2'h0, 1'b1); u_ctrl.idle(4);
    issue(mode_set_cmd, 2'h0, 1'b0, 3'h2); step(4'h0, 1'b0, 0);
    issue(row_activate_cmd, 2'h1); u_ctrl.idle(2);
    issue(read_cmd, 2'h1); issue(read_cmd, 2'h1); step(4'h2, 1'b0, 1);
    issue(read_cmd, 2'h1, 1'b1); issue(row_activate_cmd, 2'h2); step(4'h4, 1'b0, 0);
    // commands are not seen while the enable is low
    @(negedge clk_sys) clk_en = 1'b0;
    u_ctrl.idle(6);
    issue(row_activate_cmd, 2'h1);
    u_ctrl.idle(2);
    @(negedge clk_sys) clk_en = 1'b1;
    step(4'h4, 1'b0, 0);
    // reset in mid-run returns every bank to idle
    @(negedge clk_sys) rst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    u_ctrl.idle(8);
    step(4'h0, 1'b0, 0);
    issue(precharge_cmd, 2'h0, 1'b1); u_ctrl.idle(4);
    issue(mode_set_cmd, 2'h1, 1'b0, 3'h3); step(4'h0, 1'b0, 0);
    test_done();
  end
endmodule : test_sbl_cmd_legality
